// ### logic/spi_master_defines.svh
// Purpose: Offsets, field positions, reset values and counts of the serial master
// Assumes: One core clock, 8-bit register port
// Notes:   Constants only
//
// Notes on behaviour
// - Data-out bit is set up before the capturing edge of the serial clock.
// - Control bits 1:0 pick clock polarity and phase, four modes.
// - Each data register write with select active pushes a byte into a sixteen-byte transmit FIFO.
// - With select active and data queued, bytes go out oldest first.
// - Every byte sent captures one byte from data-in at the same time.
// - Each received byte enters a sixteen-byte receive FIFO; data reads pop it.
// - A write to a full transmit FIFO overwrites the oldest byte, never blocks.
// - Clearing select active empties both FIFOs.
// - Control bits 7..0: zero, mask, select choice, active, ovf en, empty en, cpol, cpha.
// - Select active drives the chosen select low; clearing returns it high.
// - A divisor register sets the serial clock rate.
// - Drained FIFO with empty enable reads status 84h; writing 04h clears flag.
// - Serial clock equals core clock over twice (divisor plus one).
`ifndef SPI_MASTER_DEFINES_SVH
`define SPI_MASTER_DEFINES_SVH

`define SM_DATA_ADDR     8'hb8
`define SM_CTRL_ADDR     8'hb9
`define SM_STATUS_ADDR   8'hba
`define SM_DIV_ADDR      8'hbb

`define SM_CTRL_RESET    8'h00
`define SM_DIV_RESET     8'h00

`define SM_ST_TX_IDLE    7
`define SM_ST_TX_FULL    6
`define SM_ST_RX_EMPTY   5
`define SM_ST_RX_FULL    4
`define SM_ST_OVF        3
`define SM_ST_EMT        2

`define SM_FIFO_DEPTH    16
`define SM_LAST_EDGE     4'hf

`endif

// ### logic/spi_master_pkg.sv
// Purpose: Types of the serial master
// Assumes: Nothing
// Notes:   Types only
`default_nettype none

package spi_master_pkg;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } bus_req_t;

    typedef struct packed {
        logic zero;
        logic irq_mask;
        logic ss_sel;
        logic ss_active;
        logic ovf_en;
        logic emt_en;
        logic cpol;
        logic cpha;
    } ctrl_t;

    typedef enum logic [1:0] {
        XS_IDLE  = 2'b00,
        XS_SHIFT = 2'b01,
        XS_DONE  = 2'b10
    } xfer_state_t;

    typedef struct packed {
        ctrl_t       ctrl;
        logic [7:0]  divisor;
        logic        flag_ovf;
        logic        flag_emt;
        xfer_state_t xs;
        logic [7:0]  div_cnt;
        logic [3:0]  edge_cnt;
        logic [7:0]  shift_tx;
        logic [7:0]  shift_rx;
        logic        sclk;
        logic        mosi;
        logic [1:0]  ss_n;
        logic        int_n;
        logic [7:0]  rd_data;
    } core_state_t;

endpackage

`default_nettype wire

// ### logic/byte_fifo.sv
// Purpose: Byte FIFO that overwrites its oldest entry when full
// Assumes: DEPTH is a power of two
// Notes:   Clear wins over push and pop
`default_nettype none
`timescale 1ns/100ps

module byte_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             clear,
    input  wire logic             push,
    input  wire logic [WIDTH-1:0] din,
    input  wire logic             pop,
    output logic      [WIDTH-1:0] dout,
    output logic                  empty,
    output logic                  full,
    output logic [$clog2(DEPTH):0] level
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [AW-1:0] wp;
        logic [AW-1:0] rp;
        logic [AW:0]   cnt;
    } fifo_state_t;

    fifo_state_t    st_reg;
    fifo_state_t    st_next;
    logic [WIDTH-1:0] mem [DEPTH];
    logic           do_pop;

    assign empty  = (st_reg.cnt == '0);
    assign full   = (st_reg.cnt == (AW+1)'(DEPTH));
    assign level  = st_reg.cnt;
    assign dout   = mem[st_reg.rp];
    assign do_pop = pop && !empty;

    always_comb begin
        st_next = st_reg;
        if (clear) begin
            st_next = '0;
        end else begin
            if (push) begin
                st_next.wp = st_reg.wp + 1'b1;
            end
            if (do_pop) begin
                st_next.rp = st_reg.rp + 1'b1;
            end
            // Full push leaves read pointer alone and overwrites oldest
            if (push && !do_pop && !full) begin
                st_next.cnt = st_reg.cnt + 1'b1;
            end else if (!push && do_pop) begin
                st_next.cnt = st_reg.cnt - 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg <= '0;
        end else begin
            st_reg <= st_next;
        end
    end

    always_ff @(posedge clk) begin
        if (push && !clear) begin
            mem[st_reg.wp] <= din;
        end
    end

    default clocking fifo_cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    a_push_counts: assert property (
        (push && !clear && !pop && !full) |=> (level == $past(level) + 1'b1))
        else $error("push did not raise fifo level");

    a_overrun_full: assert property (
        (push && !clear && full && !pop) |=> (full && $past(st_reg.rp) == st_reg.rp))
        else $error("overrun moved read pointer or left full");

endmodule // byte_fifo

`default_nettype wire

// ### logic/spi_master_fifo_port.sv
// Purpose: Host-programmed serial master with transmit and receive FIFOs
// Assumes: Register strobes one cycle long, read data one cycle later
// Notes:   Interrupt output active low, level
//
// Local design decision: the plain strobed port.
`default_nettype none
`timescale 1ns/100ps
`include "spi_master_defines.svh"

module spi_master_fifo_port #(
    parameter int DEPTH = `SM_FIFO_DEPTH
) (
    input  wire logic                      core_clk,
    input  wire logic                      rst_n,
    input  wire spi_master_pkg::bus_req_t  bus,
    output logic [7:0]                     rd_data,
    output logic                           flash_serial_clock,
    output logic                           flash_serial_out,
    input  wire logic                      flash_serial_in,
    output logic [1:0]                     slave_select_n,
    output logic                           int_n
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    spi_master_pkg::core_state_t st_reg;
    spi_master_pkg::core_state_t st_next;

    logic                  wr_data;
    logic                  wr_ctrl;
    logic                  wr_status;
    logic                  wr_div;
    logic                  rd_data_req;
    logic                  tx_pop;
    logic                  rx_pop;
    logic                  rx_push;
    logic                  fifo_clear;
    logic                  tick;
    logic [7:0]            tx_dout;
    logic                  tx_empty;
    logic                  tx_full;
    logic [7:0]            rx_dout;
    logic                  rx_empty;
    logic                  rx_full;
    logic [$clog2(DEPTH):0] tx_level;
    logic [7:0]            status_val;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
        return a == target;
    endfunction

    assign wr_data     = bus.wr && hit(bus.addr, `SM_DATA_ADDR);
    assign wr_ctrl     = bus.wr && hit(bus.addr, `SM_CTRL_ADDR);
    assign wr_status   = bus.wr && hit(bus.addr, `SM_STATUS_ADDR);
    assign wr_div      = bus.wr && hit(bus.addr, `SM_DIV_ADDR);
    assign rd_data_req = bus.rd && hit(bus.addr, `SM_DATA_ADDR);
    assign rx_pop      = rd_data_req && !rx_empty;
    assign fifo_clear  = !st_reg.ctrl.ss_active;
    assign tick        = (st_reg.xs == spi_master_pkg::XS_SHIFT)
                         && (st_reg.div_cnt == st_reg.divisor);

    always_comb begin
        status_val = 8'h00;
        status_val[`SM_ST_TX_IDLE]  = tx_empty && (st_reg.xs == spi_master_pkg::XS_IDLE);
        status_val[`SM_ST_TX_FULL]  = tx_full;
        status_val[`SM_ST_RX_EMPTY] = rx_empty;
        status_val[`SM_ST_RX_FULL]  = rx_full;
        status_val[`SM_ST_OVF]      = st_reg.flag_ovf;
        status_val[`SM_ST_EMT]      = st_reg.flag_emt;
    end

    ////////////////////////////////////////////////////////////////////////////
    // FIFOs

    byte_fifo #(.WIDTH(8), .DEPTH(DEPTH)) tx_fifo (
        .clk   (core_clk),
        .rst_n (rst_n),
        .clear (fifo_clear),
        .push  (wr_data),
        .din   (bus.wdata),
        .pop   (tx_pop),
        .dout  (tx_dout),
        .empty (tx_empty),
        .full  (tx_full),
        .level (tx_level)
    );

    byte_fifo #(.WIDTH(8), .DEPTH(DEPTH)) rx_fifo (
        .clk   (core_clk),
        .rst_n (rst_n),
        .clear (fifo_clear),
        .push  (rx_push),
        .din   (st_reg.shift_rx),
        .pop   (rx_pop),
        .dout  (rx_dout),
        .empty (rx_empty),
        .full  (rx_full),
        .level ()
    );

    ////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        st_next = st_reg;
        tx_pop  = 1'b0;
        rx_push = 1'b0;

        // Register writes
        if (wr_ctrl) begin
            st_next.ctrl      = bus.wdata;
            st_next.ctrl.zero = 1'b0;
        end
        if (wr_div) begin
            st_next.divisor = bus.wdata;
        end
        if (wr_status) begin
            st_next.flag_ovf = st_reg.flag_ovf && !bus.wdata[`SM_ST_OVF];
            st_next.flag_emt = st_reg.flag_emt && !bus.wdata[`SM_ST_EMT];
        end

        // Transfer engine
        case (st_reg.xs)
            spi_master_pkg::XS_IDLE: begin
                st_next.sclk    = st_reg.ctrl.cpol;
                st_next.div_cnt = 8'h00;
                if (st_reg.ctrl.ss_active && !tx_empty) begin
                    tx_pop           = 1'b1;
                    st_next.edge_cnt = 4'h0;
                    st_next.xs       = spi_master_pkg::XS_SHIFT;
                    if (!st_reg.ctrl.cpha) begin
                        st_next.mosi     = tx_dout[7];
                        st_next.shift_tx = {tx_dout[6:0], 1'b0};
                    end else begin
                        st_next.shift_tx = tx_dout;
                    end
                end
            end
            spi_master_pkg::XS_SHIFT: begin
                if (tick) begin
                    st_next.div_cnt  = 8'h00;
                    st_next.sclk     = !st_reg.sclk;
                    st_next.edge_cnt = st_reg.edge_cnt + 4'h1;
                    if (st_reg.edge_cnt[0] == st_reg.ctrl.cpha) begin
                        st_next.shift_rx = {st_reg.shift_rx[6:0], flash_serial_in};
                    end else if (st_reg.edge_cnt != `SM_LAST_EDGE) begin
                        st_next.mosi     = st_reg.shift_tx[7];
                        st_next.shift_tx = {st_reg.shift_tx[6:0], 1'b0};
                    end
                    if (st_reg.edge_cnt == `SM_LAST_EDGE) begin
                        st_next.xs = spi_master_pkg::XS_DONE;
                    end
                end else begin
                    st_next.div_cnt = st_reg.div_cnt + 8'h01;
                end
            end
            spi_master_pkg::XS_DONE: begin
                rx_push    = 1'b1;
                st_next.xs = spi_master_pkg::XS_IDLE;
                if (tx_empty && st_reg.ctrl.emt_en) begin
                    st_next.flag_emt = 1'b1;
                end
            end
            default: begin
                st_next.xs = spi_master_pkg::XS_IDLE;
            end
        endcase

        // Overflow event, set wins over clear
        if (wr_data && tx_full && st_reg.ctrl.ovf_en) begin
            st_next.flag_ovf = 1'b1;
        end

        // Dropping select aborts the byte in flight
        if (!st_reg.ctrl.ss_active) begin
            st_next.xs   = spi_master_pkg::XS_IDLE;
            st_next.sclk = st_reg.ctrl.cpol;
        end

        // Slave selects
        st_next.ss_n = 2'b11;
        if (st_next.ctrl.ss_active) begin
            st_next.ss_n[st_next.ctrl.ss_sel] = 1'b0;
        end

        // Interrupt
        st_next.int_n = !(((st_next.flag_ovf && st_next.ctrl.ovf_en)
                         || (st_next.flag_emt && st_next.ctrl.emt_en))
                         && !st_next.ctrl.irq_mask);

        // Read data, valid one cycle only
        st_next.rd_data = 8'h00;
        if (bus.rd) begin
            case (bus.addr)
                `SM_DATA_ADDR:   st_next.rd_data = rx_dout;
                `SM_CTRL_ADDR:   st_next.rd_data = st_reg.ctrl;
                `SM_STATUS_ADDR: st_next.rd_data = status_val;
                `SM_DIV_ADDR:    st_next.rd_data = st_reg.divisor;
                default:         st_next.rd_data = 8'h00;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // State register

    always_ff @(posedge core_clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg         <= '0;
            st_reg.ctrl    <= `SM_CTRL_RESET;
            st_reg.divisor <= `SM_DIV_RESET;
            st_reg.xs      <= spi_master_pkg::XS_IDLE;
            st_reg.ss_n    <= 2'b11;
            st_reg.int_n   <= 1'b1;
        end else begin
            st_reg <= st_next;
        end
    end

    assign rd_data            = st_reg.rd_data;
    assign flash_serial_clock = st_reg.sclk;
    assign flash_serial_out   = st_reg.mosi;
    assign slave_select_n     = st_reg.ss_n;
    assign int_n              = st_reg.int_n;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    default clocking core_cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);

    sequence s_byte_done;
        st_reg.xs == spi_master_pkg::XS_DONE;
    endsequence

    sequence s_drain_flag;
        ##1 st_reg.flag_emt ##0 (st_reg.xs == spi_master_pkg::XS_IDLE);
    endsequence

    a_select_level: assert property (
        slave_select_n[st_reg.ctrl.ss_sel] == !st_reg.ctrl.ss_active
        && slave_select_n[!st_reg.ctrl.ss_sel] == 1'b1)
        else $error("slave select does not follow active bit");

    a_fifo_reset: assert property (
        $fell(st_reg.ctrl.ss_active) |=> (tx_empty && rx_empty))
        else $error("fifos not emptied when select dropped");

    a_idle_polarity: assert property (
        (st_reg.xs == spi_master_pkg::XS_IDLE && $past(st_reg.xs) == spi_master_pkg::XS_IDLE
         && $stable(st_reg.ctrl)) |-> (flash_serial_clock == st_reg.ctrl.cpol))
        else $error("idle serial clock not at polarity");

    a_data_setup: assert property (
        ($changed(flash_serial_clock) && st_reg.xs != spi_master_pkg::XS_IDLE
         && flash_serial_clock == !(st_reg.ctrl.cpol ^ st_reg.ctrl.cpha))
        |-> $stable(flash_serial_out))
        else $error("data out moved on capturing edge");

    a_rx_read: assert property (
        (rd_data_req && !rx_empty) |=> (rd_data == $past(rx_dout)))
        else $error("data read did not return receive head");

    a_divider_rate: assert property (
        (st_reg.xs == spi_master_pkg::XS_SHIFT && st_reg.div_cnt != st_reg.divisor
         && st_reg.ctrl.ss_active && $stable(st_reg.divisor)) |=> $stable(flash_serial_clock))
        else $error("serial clock toggled before divisor count");

    a_empty_event: assert property (
        (s_byte_done and (tx_empty && st_reg.ctrl.emt_en && st_reg.ctrl.ss_active
         && !wr_data)) |-> s_drain_flag)
        else $error("drained fifo did not raise empty flag");

    a_irq_level: assert property (
        int_n == !(((st_reg.flag_ovf && st_reg.ctrl.ovf_en)
                  || (st_reg.flag_emt && st_reg.ctrl.emt_en)) && !st_reg.ctrl.irq_mask))
        else $error("interrupt output disagrees with flags");

    a_rx_capture: assert property (
        s_byte_done |=> (rx_empty == 1'b0))
        else $error("finished byte not stored in receive fifo");

    sequence s_last_tick;
        tick && st_reg.edge_cnt == `SM_LAST_EDGE && st_reg.ctrl.ss_active;
    endsequence

    a_byte_end: assert property (
        s_last_tick |=> s_byte_done)
        else $error("byte did not end after sixteen clock edges");

    a_first_bit: assert property (
        (st_reg.xs == spi_master_pkg::XS_IDLE && st_reg.ctrl.ss_active && !tx_empty
         && !st_reg.ctrl.cpha) |=> (st_reg.xs == spi_master_pkg::XS_SHIFT
         && flash_serial_out == $past(tx_dout[7])))
        else $error("first bit out is not the oldest byte msb");

    a_overflow_flag: assert property (
        (wr_data && tx_level == ($clog2(DEPTH) + 1)'(DEPTH) && st_reg.ctrl.ovf_en)
        |=> st_reg.flag_ovf)
        else $error("write to full fifo did not raise overflow flag");

    a_flag_clear: assert property (
        (wr_status && bus.wdata[`SM_ST_EMT] && st_reg.xs != spi_master_pkg::XS_DONE)
        |=> !st_reg.flag_emt)
        else $error("writing one did not clear empty flag");

endmodule // spi_master_fifo_port

`default_nettype wire

// ### verification/spi_slave_model.sv
// Purpose: Behavioural serial slave on the far side of the master
// Assumes: Select low on either select line frames the bytes
// Notes:   Byte 0 answers a5, each later byte the inverse of the last byte received
`default_nettype none
`timescale 1ns/100ps

module spi_slave_model (
    input  wire logic sclk,
    input  wire logic mosi,
    input  wire logic sel_n,
    input  wire logic cpol,
    input  wire logic cpha,
    output logic      miso
);
    logic [7:0] rx_sr;
    logic [7:0] tx_sr;
    int         nbits;

    initial begin
        miso  = 1'b0;
        rx_sr = 8'h00;
        tx_sr = 8'ha5;
        nbits = 0;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Frame start, first bit ahead of the first edge in phase 0
    always @(negedge sel_n) begin
        tx_sr = 8'ha5;
        nbits = 0;
        if (!cpha) begin
            miso  = tx_sr[7];
            tx_sr = {tx_sr[6:0], 1'b0};
        end
    end

    // Released line inverts its last value
    always @(posedge sel_n) begin
        miso = ~miso;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Sample on capturing edge, shift on the other
    always @(sclk) begin
        if (!sel_n) begin
            if ((sclk != cpol) ^ cpha) begin
                rx_sr = {rx_sr[6:0], mosi};
                nbits = nbits + 1;
                if (nbits == 8) begin
                    nbits = 0;
                    tx_sr = ~rx_sr;
                end
            end else begin
                miso  = tx_sr[7];
                tx_sr = {tx_sr[6:0], 1'b0};
            end
        end
    end
endmodule // spi_slave_model

`default_nettype wire

// ### verification/spi_master_fifo_port_tb_top.sv
// Purpose: Self-checking bench of the serial master
// Assumes: Register port with read data one cycle after the strobe
// Notes:   Register rows first, then transfers in all modes and overrun
`default_nettype none
`timescale 1ns/100ps

module spi_master_fifo_port_tb_top;
    logic                     core_clk;
    logic                     rst_n;
    spi_master_pkg::bus_req_t bus;
    logic [7:0]               rd_data;
    logic                     sclk;
    logic                     mosi;
    logic                     miso;
    logic [1:0]               ss_n;
    logic                     int_n;
    logic                     mcpol;
    logic                     mcpha;
    int                       errors;
    int                       checked;

    spi_master_fifo_port u_spi_master_fifo_port (
        .core_clk           (core_clk),
        .rst_n              (rst_n),
        .bus                (bus),
        .rd_data            (rd_data),
        .flash_serial_clock (sclk),
        .flash_serial_out   (mosi),
        .flash_serial_in    (miso),
        .slave_select_n     (ss_n),
        .int_n              (int_n)
    );

    spi_slave_model u_spi_slave_model (
        .sclk  (sclk),
        .mosi  (mosi),
        .sel_n (&ss_n),
        .cpol  (mcpol),
        .cpha  (mcpha),
        .miso  (miso)
    );

    initial begin
        core_clk = 1'b0;
        forever #2 core_clk = ~core_clk;
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Bus and compare tasks
    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("unexpected %s: expected %h, seen %h", what, exp, seen);
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk);
        bus.addr  <= a;
        bus.wdata <= d;
        bus.wr    <= 1'b1;
        @(posedge core_clk);
        bus.wr    <= 1'b0;
        #1;
    endtask

    task automatic rdchk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] exp);
        @(posedge core_clk);
        bus.addr <= a;
        bus.rd   <= 1'b1;
        @(posedge core_clk);
        bus.rd   <= 1'b0;
        #1;
        check("register", rd_data & m, exp);
    endtask

    task automatic settle;
        repeat (2) @(posedge core_clk);
        #1;
    endtask

    task automatic summarize;
        $display("checks %0d, errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask

    initial begin
        repeat (30000) @(posedge core_clk);
        errors++;
        $display("unexpected watchdog expiry");
        summarize();
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Main sequence
    initial begin
        logic [31:0] rows [6];
        logic [7:0]  txb [4];
        logic [7:0]  ctl;
        logic [1:0]  md;
        logic        sel;
        realtime     t0;
        int          n;
        rows = '{32'hbb5a_bb5a, 32'hb98f_b90f, 32'hb900_b900,
                 32'hbc77_bb5a, 32'hbb00_bc00, 32'hb833_baa0};
        txb = '{8'h55, 8'haa, 8'h87, 8'h78};
        errors = 0;
        checked = 0;
        rst_n = 1'b0;
        bus = '0;
        mcpol = 1'b0;
        mcpha = 1'b0;
        repeat (16) @(posedge core_clk);
        check("reset pins", {3'h0, int_n, ss_n, sclk, mosi}, 8'h1c);
        rst_n <= 1'b1;
        rdchk(8'hb9, 8'hff, 8'h00);
        rdchk(8'hbb, 8'hff, 8'h00);
        foreach (rows[i]) begin
            wr(rows[i][31:24], rows[i][23:16]);
            rdchk(rows[i][15:8], 8'hff, rows[i][7:0]);
        end
        for (int m = 0; m < 4; m++) begin
            md = 2'(m);
            sel = md[1] & md[0];
            ctl = {2'b00, sel, 3'b011, md};
            mcpol = md[1];
            mcpha = md[0];
            wr(8'hb9, ctl);
            wr(8'hbb, 8'(m));
            wr(8'hb9, ctl | 8'h10);
            settle();
            check("select", {6'h00, ss_n}, sel ? 8'h01 : 8'h02);
            foreach (txb[i]) wr(8'hb8, txb[i]);
            @(sclk);
            t0 = $realtime;
            @(sclk);
            check("half period", 8'(int'(($realtime - t0) / 4.0)), 8'(m + 1));
            n = 0;
            while (int_n !== 1'b0 && n < 2000) begin
                @(posedge core_clk);
                #1;
                n++;
            end
            check("interrupt wait", 8'(n < 2000), 8'h01);
            rdchk(8'hba, 8'hff, 8'h84);
            check("interrupt", {7'h00, int_n}, 8'h00);
            wr(8'hba, 8'h04);
            settle();
            check("interrupt", {7'h00, int_n}, 8'h01);
            rdchk(8'hba, 8'hff, 8'h80);
            rdchk(8'hb8, 8'hff, 8'ha5);
            for (int i = 1; i < 4; i++) begin
                rdchk(8'hb8, 8'hff, ~txb[i - 1]);
            end
            rdchk(8'hba, 8'hff, 8'ha0);
            wr(8'hb9, ctl);
            settle();
            check("select", {6'h00, ss_n}, 8'h03);
        end
        mcpol = 1'b0;
        mcpha = 1'b0;
        wr(8'hb9, 8'h00);
        wr(8'hbb, 8'hff);
        wr(8'hb9, 8'h58);
        repeat (18) wr(8'hb8, 8'h3c);
        rdchk(8'hba, 8'hff, 8'h68);
        settle();
        check("masked interrupt", {7'h00, int_n}, 8'h01);
        wr(8'hb9, 8'h18);
        settle();
        check("interrupt", {7'h00, int_n}, 8'h00);
        wr(8'hb9, 8'h08);
        rdchk(8'hba, 8'hf0, 8'ha0);
        check("select", {6'h00, ss_n}, 8'h03);
        wr(8'hba, 8'h08);
        settle();
        check("interrupt", {7'h00, int_n}, 8'h01);
        wr(8'hbb, 8'h00);
        wr(8'hb9, 8'h10);
        for (int i = 0; i < 17; i++) wr(8'hb8, (i == 15) ? 8'h0f : 8'h5a);
        repeat (400) @(posedge core_clk);
        rdchk(8'hba, 8'hff, 8'h90);
        rdchk(8'hb8, 8'hff, 8'hf0);
        rdchk(8'hb8, 8'hff, 8'ha5);
        summarize();
    end
endmodule // spi_master_fifo_port_tb_top

`default_nettype wire
